/* File: pkg/usart_rx_pkg.sv */
package usart_rx_pkg;
  localparam logic [7:0] RX_CTRL_ADDR   = 8'h18;
  localparam logic [7:0] TX_CTRL_ADDR   = 8'h98;
  localparam logic [7:0] DIVISOR_ADDR   = 8'h99;
  localparam logic [7:0] IRQ_STAT_ADDR  = 8'hA0;
  localparam logic [7:0] IRQ_EN_ADDR    = 8'hA1;
  localparam logic [7:0] IRQ_CLR_ADDR   = 8'hA2;
  localparam logic [7:0] RX_DATA_ADDR   = 8'hA3;
  localparam int SERIAL_PORT_ENABLE_BIT  = 7;
  localparam int RX9_BIT   = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT  = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT  = 4;
  localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int FRAMING_ERROR_FLAG_BIT  = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT  = 1;
  localparam int RECEIVED_NINTH_BIT_BIT  = 0;
  localparam int CLOCK_SOURCE_SELECT_BIT  = 7;
  localparam int SYNC_BIT  = 4;
  localparam int HIGH_SPEED_BAUD_SELECT_BIT  = 2;
  localparam int SHIFT_REGISTER_EMPTY_BIT  = 1;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
  localparam logic [5:0] DIV_LOW_SPEED  = 6'd63;
  localparam logic [5:0] DIV_HIGH_SPEED = 6'd15;
  localparam logic [5:0] DIV_SYNC       = 6'd3;
  localparam logic [5:0] SAMPLE_MID     = 6'd7;
  localparam int IRQ_RX    = 0;
  localparam int IRQ_FRAMING_ERROR_FLAG  = 1;
  localparam int IRQ_OVERRUN_ERROR_FLAG  = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage

/* File: pkg/baud_if.sv */
`timescale 1ns/1ps
interface baud_if;
  logic [7:0] divisor;
  logic       reload;
  logic       tick;
  modport gen (input divisor, input reload, output tick);
  modport user (output divisor, output reload, input tick);
endinterface

/* File: rtl/baud_generator.sv */
`timescale 1ns/1ps
module baud_generator
  import usart_rx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  baud_if.gen      bif
);
  logic [7:0] count_reg;
  logic       tick_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_reg <= DIVISOR_RESET;
      tick_reg  <= 1'b0;
    end else if (bif.reload) begin
      count_reg <= bif.divisor;
      tick_reg  <= 1'b0;
    end else if (count_reg == 8'h00) begin
      count_reg <= bif.divisor;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg - 8'h01;
      tick_reg  <= 1'b0;
    end
  end

  assign bif.tick = tick_reg;
endmodule // baud_generator

/* File: rtl/usart_receive_control.sv */
`timescale 1ns/1ps
module usart_receive_control
  import usart_rx_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            rx_pin_claim,
  output logic            tx_pin_claim,
  output logic            sync_clk_out,
  output logic            irq
);
  import usart_rx_pkg::*;

  typedef enum logic [3:0] {
    IDLE  = 4'b0001,
    START = 4'b0010,
    DATA  = 4'b0100,
    STOP  = 4'b1000
  } rx_state_e;

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  baud_if bif ();

  logic [7:0] rx_ctrl_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] divisor_reg;
  logic       div_wr_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_en_reg;
  logic [7:0] rx_data_reg;
  logic       data_full_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic       rx_claim_reg;
  logic       tx_claim_reg;
  logic       sclk_reg;
  rx_state_e  state_reg;
  logic [5:0] sub_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [1:0] samp_reg;
  logic [5:0] sub_top;
  logic       async_mode;
  logic       rx_active;
  logic       bit_level;
  logic       sample_pt;
  logic       bit_end;
  logic [3:0] bits_needed;
  logic       char_done;
  logic       char_accept;
  logic       char_overrun;
  logic       frame_bad;
  logic       buf_read;
  logic       clr_wr;
  logic       single_receive_enable_done;

  assign async_mode = !tx_ctrl_reg[SYNC_BIT];
  assign buf_read   = rd_stb && addr == RX_DATA_ADDR;
  assign clr_wr     = wr_stb && addr == IRQ_CLR_ADDR;

  always_comb begin
    if (!async_mode) begin
      sub_top = DIV_SYNC;
    end else if (tx_ctrl_reg[HIGH_SPEED_BAUD_SELECT_BIT]) begin
      sub_top = DIV_HIGH_SPEED;
    end else begin
      sub_top = DIV_LOW_SPEED;
    end
  end

  // Continuous wins; single only counts as master in sync mode
  assign rx_active = rx_ctrl_reg[SERIAL_PORT_ENABLE_BIT] && (rx_ctrl_reg[CONTINUOUS_RECEIVE_ENABLE_BIT] ||
    (!async_mode && tx_ctrl_reg[CLOCK_SOURCE_SELECT_BIT] &&
     rx_ctrl_reg[SINGLE_RECEIVE_ENABLE_BIT]));

  assign bits_needed = rx_ctrl_reg[RX9_BIT] ? 4'd9 : 4'd8;
  // Third vote comes straight from the pin so all three samples count
  assign bit_level   = majority({samp_reg, rx_pin});
  assign sample_pt   = bif.tick && sub_reg == SAMPLE_MID + 6'd2;
  assign bit_end     = bif.tick && sub_reg == sub_top;

  assign bif.divisor = divisor_reg;
  assign bif.reload  = div_wr_reg;

  baud_generator u_baud (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .bif      (bif)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_wr_reg <= 1'b0;
    end else begin
      div_wr_reg <= wr_stb && addr == DIVISOR_ADDR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      samp_reg <= 2'b11;
    end else if (bif.tick && sub_reg >= SAMPLE_MID &&
                 sub_reg <= SAMPLE_MID + 6'd2) begin
      samp_reg <= {samp_reg[0], rx_pin};
    end
  end

  // Receive sequencer; sync mode uses a shorter bit (sub_top = DIV_SYNC) with the
  // internally generated clock, no pin-edge start detection.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg   <= IDLE;
      sub_reg     <= 6'd0;
      bit_cnt_reg <= 4'd0;
      shift_reg   <= 9'h000;
    end else if (!rx_active) begin
      state_reg <= IDLE;
      sub_reg   <= 6'd0;
    end else begin
      if (bif.tick) begin
        sub_reg <= (sub_reg == sub_top) ? 6'd0 : sub_reg + 6'd1;
      end
      case (state_reg)
        IDLE: begin
          sub_reg <= 6'd0;
          if (!async_mode || !rx_pin) begin
            state_reg <= async_mode ? START : DATA;
            bit_cnt_reg <= 4'd0;
          end
        end
        START: begin
          if (sample_pt && bit_level) begin
            state_reg <= IDLE;
          end else if (bit_end) begin
            state_reg <= DATA;
          end
        end
        DATA: begin
          if (sample_pt) begin
            shift_reg <= {bit_level, shift_reg[8:1]};
          end
          if (bit_end) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg + 4'd1 == bits_needed) begin
              state_reg <= async_mode ? STOP : IDLE;
            end
          end
        end
        STOP: begin
          if (sample_pt) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Character completes at stop sample (async) or last bit (sync)
  assign char_done = rx_active && ((state_reg == STOP && sample_pt) ||
    (!async_mode && state_reg == DATA && bit_end &&
     bit_cnt_reg + 4'd1 == bits_needed));
  assign frame_bad = async_mode && !bit_level;
  logic [8:0] char_word;
  assign char_word = rx_ctrl_reg[RX9_BIT] ? shift_reg :
                     {1'b0, shift_reg[8:1]};
  assign char_accept = char_done && !(async_mode &&
    rx_ctrl_reg[RX9_BIT] && rx_ctrl_reg[ADDRESS_DETECT_ENABLE_BIT] &&
    !char_word[8]) && !rx_ctrl_reg[OVERRUN_ERROR_FLAG_BIT];
  assign char_overrun = char_accept && data_full_reg && !buf_read;
  assign single_receive_enable_done = char_done && !async_mode;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_ctrl_reg <= RX_CTRL_RESET;
    end else begin
      if (wr_stb && addr == RX_CTRL_ADDR) begin
        rx_ctrl_reg[7:3] <= wdata[7:3];
        if (!wdata[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
          rx_ctrl_reg[OVERRUN_ERROR_FLAG_BIT] <= 1'b0;
        end
      end else if (single_receive_enable_done && !rx_ctrl_reg[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
        rx_ctrl_reg[SINGLE_RECEIVE_ENABLE_BIT] <= 1'b0;
      end
      if (char_overrun) begin
        rx_ctrl_reg[OVERRUN_ERROR_FLAG_BIT] <= 1'b1;
      end
      if (char_accept && !char_overrun) begin
        rx_ctrl_reg[FRAMING_ERROR_FLAG_BIT] <= frame_bad;
        rx_ctrl_reg[RECEIVED_NINTH_BIT_BIT] <= char_word[8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_data_reg   <= 8'h00;
      data_full_reg <= 1'b0;
    end else if (char_accept && (!data_full_reg || buf_read)) begin
      rx_data_reg   <= char_word[7:0];
      data_full_reg <= 1'b1;
    end else if (buf_read) begin
      data_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_ctrl_reg <= TX_CTRL_RESET;
      divisor_reg <= DIVISOR_RESET;
      irq_en_reg  <= IRQ_RESET;
    end else if (wr_stb) begin
      if (addr == TX_CTRL_ADDR) begin
        tx_ctrl_reg <= (wdata & TX_CTRL_WMASK) |
                       (tx_ctrl_reg & ~TX_CTRL_WMASK);
      end else if (addr == DIVISOR_ADDR) begin
        divisor_reg <= wdata;
      end else if (addr == IRQ_EN_ADDR) begin
        irq_en_reg <= wdata[2:0];
      end
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_stat_reg <= IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(clr_wr ? wdata[2:0] : 3'b000)) |
        {char_overrun, char_accept && frame_bad, char_accept};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (!rd_stb) begin
      rdata_reg <= 8'h00;
    end else if (addr == RX_CTRL_ADDR) begin
      rdata_reg <= rx_ctrl_reg;
    end else if (addr == TX_CTRL_ADDR) begin
      rdata_reg <= tx_ctrl_reg;
    end else if (addr == DIVISOR_ADDR) begin
      rdata_reg <= divisor_reg;
    end else if (addr == IRQ_STAT_ADDR) begin
      rdata_reg <= {5'b00000, irq_stat_reg};
    end else if (addr == IRQ_EN_ADDR) begin
      rdata_reg <= {5'b00000, irq_en_reg};
    end else if (addr == RX_DATA_ADDR) begin
      rdata_reg <= rx_data_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_claim_reg <= 1'b0;
      tx_claim_reg <= 1'b0;
      sclk_reg     <= 1'b1;
    end else begin
      rx_claim_reg <= rx_ctrl_reg[SERIAL_PORT_ENABLE_BIT];
      tx_claim_reg <= rx_ctrl_reg[SERIAL_PORT_ENABLE_BIT];
      if (!async_mode && tx_ctrl_reg[CLOCK_SOURCE_SELECT_BIT] && rx_active &&
          state_reg != IDLE) begin
        if (bif.tick && (sub_reg == 6'd1 || sub_reg == sub_top)) begin
          sclk_reg <= sub_reg == sub_top;
        end
      end else begin
        sclk_reg <= 1'b1;
      end
    end
  end

  assign rdata        = rdata_reg;
  assign irq          = irq_reg;
  assign rx_pin_claim = rx_claim_reg;
  assign tx_pin_claim = tx_claim_reg;
  assign sync_clk_out = sclk_reg;
endmodule // usart_receive_control

/* File: test/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  input  wire logic core_clk,
  output logic      rx_pin
);
  initial rx_pin = 1'b1;
  // Idle high, low start bit, data lsb first, then stop
  task automatic send(input logic [8:0] d, input int n, input int bc,
                      input logic stp, input logic glitch);
    logic [9:0] f;
    f = {d, 1'b0};
    for (int b = 0; b < n + 2; b++) begin
      for (int c = 0; c < bc; c++) begin
        @(posedge core_clk);
        if (b > n)
          rx_pin <= stp;
        else
          rx_pin <= f[b] ^ (glitch && b > 0 && c == bc / 2);
      end
    end
    @(posedge core_clk);
    rx_pin <= 1'b1;
  endtask
endmodule // serial_peer

/* File: test/usart_rx_props.sv */
`timescale 1ns/1ps
module usart_rx_props
  import usart_rx_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       rx_pin,
  input wire logic       rx_pin_claim,
  input wire logic       tx_pin_claim,
  input wire logic       sync_clk_out,
  input wire logic       irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_claim_follow: assert property (wr_stb && addr == RX_CTRL_ADDR |->
    ##2 rx_pin_claim == $past(wdata[SERIAL_PORT_ENABLE_BIT], 2))
    else $error("pin claim does not follow enable");
  a_claims_equal: assert property (tx_pin_claim == rx_pin_claim)
    else $error("pin claims differ");
  a_irq_masked: assert property (wr_stb && addr == IRQ_EN_ADDR &&
    wdata == 8'h00 |-> ##2 !irq)
    else $error("interrupt high with no enable");
  a_unmapped_zero: assert property (rd_stb && addr == 8'h55 |=>
    rdata == 8'h00)
    else $error("unmapped read not zero");
  a_tx_unimpl: assert property (rd_stb && addr == TX_CTRL_ADDR |=>
    !rdata[3])
    else $error("unimplemented bit reads one");
  a_div_readback: assert property (wr_stb && addr == DIVISOR_ADDR ##2
    rd_stb && addr == DIVISOR_ADDR |=> rdata == $past(wdata, 3))
    else $error("divisor readback wrong");
  a_rx_readback: assert property (wr_stb && addr == RX_CTRL_ADDR ##2
    rd_stb && addr == RX_CTRL_ADDR |=>
    (rdata & 8'hC8) == ($past(wdata, 3) & 8'hC8))
    else $error("receive control readback wrong");
  a_reset_out: assert property (disable iff (1'b0)
    !rst_b ##1 !rst_b |-> rdata == 8'h00 && !irq && !rx_pin_claim &&
    sync_clk_out)
    else $error("outputs not at reset level");
  c_irq: cover property (irq);
  c_pop: cover property (rd_stb && addr == RX_DATA_ADDR);
  c_sync: cover property ($fell(sync_clk_out));
endmodule // usart_rx_props

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import usart_rx_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rdata, got;
  logic        rx_pin, rx_pin_claim, tx_pin_claim, sync_clk_out, irq;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] seed = 32'h73eb_c7df;
  logic [7:0]  exp_q[$];
  always #4 core_clk = ~core_clk;
  usart_receive_control i_dut (.core_clk, .rst_b, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .rx_pin, .rx_pin_claim, .tx_pin_claim, .sync_clk_out,
    .irq);
  serial_peer i_peer (.core_clk, .rx_pin);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask
  task automatic pop;
    rc(RX_DATA_ADDR, exp_q.pop_front());
  endtask
  // Model: every accepted character is queued for the next buffer read
  task automatic rx_char(input logic [8:0] d, input int nb, input int bc,
                         input logic stp, input logic acc);
    i_peer.send(d, nb, bc, stp, 1'b1);
    repeat (bc) @(posedge core_clk);
    if (acc)
      exp_q.push_back(d[7:0]);
  endtask
  task automatic wait_sck(input logic v);
    while (sync_clk_out !== v && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rc(RX_CTRL_ADDR, RX_CTRL_RESET);
    rc(TX_CTRL_ADDR, TX_CTRL_RESET);
    rc(DIVISOR_ADDR, DIVISOR_RESET);
    rc(IRQ_STAT_ADDR, 8'h00);
    rc(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(DIVISOR_ADDR, seed[7:0]);
      rc(DIVISOR_ADDR, seed[7:0]);
    end
    wr(TX_CTRL_ADDR, 8'h04);
    wr(DIVISOR_ADDR, 8'h00);
    wr(IRQ_EN_ADDR, 8'h07);
    wr(RX_CTRL_ADDR, 8'h90);
    repeat (2) @(posedge core_clk);
    chk({7'h0, rx_pin_claim}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      rx_char({1'b0, seed[7:0]}, 8, 16, 1'b1, 1'b1);
      rc(IRQ_STAT_ADDR, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wr(IRQ_EN_ADDR, 8'h00);
      repeat (2) @(posedge core_clk);
      chk({7'h0, irq}, 8'h00);
      wr(IRQ_EN_ADDR, 8'h07);
      pop();
      wr(IRQ_CLR_ADDR, 8'h07);
      rc(IRQ_STAT_ADDR, 8'h00);
    end
    rx_char(9'h03C, 8, 16, 1'b1, 1'b1);
    rx_char(9'h0C3, 8, 16, 1'b1, 1'b0);
    rc(IRQ_STAT_ADDR, 8'h05);
    rc(RX_CTRL_ADDR, 8'h92);
    pop();
    wr(RX_CTRL_ADDR, 8'h80);
    rc(RX_CTRL_ADDR, 8'h80);
    wr(RX_CTRL_ADDR, 8'h90);
    wr(IRQ_CLR_ADDR, 8'h07);
    rx_char(9'h0A5, 8, 16, 1'b0, 1'b1);
    rc(RX_CTRL_ADDR, 8'h94);
    rd(IRQ_STAT_ADDR);
    chk(got & 8'h02, 8'h02);
    pop();
    rx_char(9'h05A, 8, 16, 1'b1, 1'b1);
    rc(RX_CTRL_ADDR, 8'h90);
    pop();
    wr(RX_CTRL_ADDR, 8'hD8);
    wr(IRQ_CLR_ADDR, 8'h07);
    rx_char(9'h011, 8'd9, 16, 1'b1, 1'b0);
    rc(IRQ_STAT_ADDR, 8'h00);
    rx_char(9'h122, 9, 16, 1'b1, 1'b1);
    rc(RX_CTRL_ADDR, 8'hD9);
    pop();
    wr(RX_CTRL_ADDR, 8'hD0);
    rx_char(9'h033, 9, 16, 1'b1, 1'b1);
    rc(RX_CTRL_ADDR, 8'hD0);
    pop();
    wr(RX_CTRL_ADDR, 8'h90);
    for (int m = 0; m < 2; m++) begin
      wr(TX_CTRL_ADDR, m ? 8'h00 : 8'h04);
      wr(DIVISOR_ADDR, m ? 8'h00 : 8'h02);
      seed = xs(seed);
      rx_char({1'b0, seed[7:0]}, 8, m ? 64 : 48, 1'b1, 1'b1);
      pop();
    end
    wr(RX_CTRL_ADDR, 8'h80);
    wr(DIVISOR_ADDR, 8'h01);
    wr(TX_CTRL_ADDR, 8'h94);
    wr(RX_CTRL_ADDR, 8'hA0);
    n = 0;
    wait_sck(1'b0);
    wait_sck(1'b1);
    n = 0;
    wait_sck(1'b0);
    wait_sck(1'b1);
    chk(n[7:0], 8'd8);
    repeat (120) @(posedge core_clk);
    rd(RX_CTRL_ADDR);
    chk(got & 8'h20, 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    rc(DIVISOR_ADDR, DIVISOR_RESET);
    chk({7'h0, rx_pin_claim}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    print_verdict();
  end
endmodule // testbench
bind usart_receive_control usart_rx_props i_props (.core_clk, .rst_b, .addr,
  .wdata, .wr_stb, .rd_stb, .rdata, .rx_pin, .rx_pin_claim, .tx_pin_claim,
  .sync_clk_out, .irq);
